// ===== src/serial_config_power_reset_regs.sv
// Serial configuration, power-down and reset register bank of a clock synchronizer.
//
// Behaviour
// - Config upper nibble mirrors lower, bit-reversed.
// - Long-instruction bit reads as one, always.
// - Soft reset defaults all but config; host clears.
// - Soft reset keeps straps latched at hard reset.
// - LSB-first bit; MSB-first waits for update.
// - Config bit 0 enables serial data output.
// - Part identifier registers are read-only.
// - Readback select picks pending or active values.
// - Update strobe equals update pin, self-clears.
// - Power register default comes from straps.
// - Bit 7 powers HSTL down, 6 CMOS up.
// - Bit 5 powers doubler; also needs output enable.
// - Bit 4 powers down system clock multiplier.
// - Bits 3,2 power down reference inputs.
// - Full power-down equals power-down pin.
// - Digital power-down gates digital clock, keeps port.
// - Pulse bit 7 clears tuning-word history.
// - Pulse bit 5 clears interrupt and status.
// - Pulse bits 4..0 reset loop path blocks.
// - Held bit 7 mutes synthesizer fundamental only.
// - Held bits 3,2 reset prescalers asynchronously.
// - Held bits 1,0 reset integer dividers.
// - Buffered writes apply only on update.
//
// Divider resets leave as levels.
// Soft reset holds defaults.
`include "serial_config_power_reset_regs_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module serial_config_power_reset_regs
    import serial_config_power_reset_regs_pkg::*;
#(
    parameter logic [7:0] PART_IDENTIFIER_HIGH_LOW  = 8'h5A,  // Arbitrary identification value.
    parameter logic [7:0] PART_IDENTIFIER_HIGH_HIGH = 8'hA5,  // Arbitrary identification value.
    parameter int         STRAP_WIDTH  = 4
) (
    input  wire logic                   i_clk,
    input  wire logic                   i_sys_rst,
    input  wire reg_req_t               i_req,
    input  wire logic                   i_io_update_pin,
    input  wire logic                   i_power_down_pin,
    input  wire logic [STRAP_WIDTH-1:0] i_startup_strap_pins,
    output logic [7:0]                  o_rdata,
    output logic                        o_rd_valid,
    output logic                        o_lsb_first,
    output logic                        o_serial_out_pin_en,
    output logic                        o_soft_reset,
    output logic                        o_read_buffered,
    output logic                        o_io_update,
    output logic [STRAP_WIDTH-1:0]      o_strap_values,
    output power_ctrl_t                 o_power,
    output logic                        o_full_power_down,
    output pulse_rst_t                  o_pulse_rst,
    output held_rst_t                   o_held_rst
);

    // ****************************************************************
    // Elaboration checks.
    // ****************************************************************

    // The strap mapping reads strap bits 0 and 1, so at least two are needed.
    if (STRAP_WIDTH < 2 || STRAP_WIDTH > 8) begin : g_bad_strap_width
        $error("STRAP_WIDTH must lie between 2 and 8.");
    end

    // ****************************************************************
    // Functions.
    // ****************************************************************

    // Address match used by every write decoder below.
    function automatic logic hit(input logic [15:0] addr, input logic [15:0] reg_addr);
        hit = (addr == reg_addr);
    endfunction : hit

    // Power register default derived from the latched straps.
    function automatic power_ctrl_t strap_to_power(input logic [STRAP_WIDTH-1:0] straps);
        power_ctrl_t p;
        // Zeros first.
        p                   = power_ctrl_t'(`POWER_PRE_STRAP);
        p.en_cmos_driver    = straps[`STRAP_CMOS_BIT];
        p.en_output_doubler = straps[`STRAP_DOUBLER_BIT];
        strap_to_power      = p;
    endfunction : strap_to_power

    // ****************************************************************
    // Pin synchronisers.
    // ****************************************************************

    localparam int PW = STRAP_WIDTH + 2;  // Straps plus update and power-down pins.

    logic [PW-1:0] pins_raw;    // Pin levels as they arrive.
    logic [PW-1:0] sync1_q;     // First stage, read only by the second stage.
    logic [PW-1:0] sync2_q;     // Second stage.
    logic [PW-1:0] sync3_q;     // Third stage.
    logic [PW-1:0] pins_q;      // Accepted pin levels.
    logic          upd_pin_d1_q; // Previous accepted update pin level.

    assign pins_raw = {i_io_update_pin, i_power_down_pin, i_startup_strap_pins};

    // Three synchroniser flip-flops and an accepted-level flip-flop per pin; a new level counts once stages two and three agree.
    genvar gi;
    for (gi = 0; gi < PW; gi++) begin : g_pin_sync
        always_ff @(posedge i_clk or posedge i_sys_rst) begin
            if (i_sys_rst) begin
                sync1_q[gi] <= 1'b0;
                sync2_q[gi] <= 1'b0;
                sync3_q[gi] <= 1'b0;
                pins_q[gi]  <= 1'b0;
            end else begin
                sync1_q[gi] <= pins_raw[gi];
                sync2_q[gi] <= sync1_q[gi];
                sync3_q[gi] <= sync2_q[gi];
                // Only an agreed level replaces the accepted one.
                if (sync2_q[gi] == sync3_q[gi]) begin
                    pins_q[gi] <= sync3_q[gi];
                end
            end
        end
    end

    // Remembers the update pin so that its rising edge can be found.
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            // Idle low.
            upd_pin_d1_q <= 1'b0;
        end else begin
            upd_pin_d1_q <= pins_q[PW-1];
        end
    end

    // ****************************************************************
    // Strap capture after hard reset.
    // ****************************************************************

    logic [2:0]             settle_q;   // Cycles since hard reset release.
    logic                   strap_ok_q; // Straps have been captured.
    logic [STRAP_WIDTH-1:0] strap_q;    // Straps held since the last hard reset.
    logic                   strap_load; // One-cycle capture moment.

    assign strap_load = !strap_ok_q && (settle_q == `STRAP_SETTLE_CYCLES);

    // Waits for the synchronisers to fill, then latches the straps once.
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            // Restart.
            settle_q   <= 3'h0;
            strap_ok_q <= 1'b0;
            strap_q    <= '0;
        end else if (!strap_ok_q) begin
            settle_q <= settle_q + 3'h1;
            if (strap_load) begin
                // Capture once.
                strap_ok_q <= 1'b1;
                strap_q    <= pins_q[STRAP_WIDTH-1:0];
            end
        end
    end

    // ****************************************************************
    // Serial port configuration.
    // ****************************************************************

    logic [3:0] cfg_q;           // Lower nibble as written.
    logic       lsb_active_q;    // Bit order in effect on the port.
    logic       soft_rst;        // Soft reset level.
    logic       sw_update;       // Update strobe written by the host.
    logic       io_update;       // Update from pin or strobe.
    logic [7:0] cfg_read;        // Full register value as read.
    logic       wr_cfg;          // Write to the configuration register.

    assign wr_cfg   = i_req.wr && hit(i_req.addr, `ADDR_SERIAL_PORT_CONFIG);
    assign soft_rst = cfg_q[`CFG_SOFT_RESET_BIT];
    assign cfg_read = {cfg_q[0], cfg_q[1], cfg_q[2], cfg_q[3], cfg_q};

    // Holds the lower nibble; soft reset never touches this register.
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            // Bit 3 set.
            cfg_q <= `CFG_LOW_RESET;
        end else if (wr_cfg) begin
            cfg_q <= i_req.wdata[3:0];
            cfg_q[`CFG_LONG_INSTR_BIT] <= 1'b1;
        end
    end

    // LSB-first takes effect at once, the return to MSB-first on an update.
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            // MSB first.
            lsb_active_q <= 1'b0;
        end else if (cfg_q[`CFG_LSB_FIRST_BIT]) begin
            lsb_active_q <= 1'b1;
        end else if (io_update) begin
            lsb_active_q <= 1'b0;
        end
    end

    // ****************************************************************
    // Serial options and update strobe.
    // ****************************************************************

    logic rb_sel_q;    // Readback of pending values selected.
    logic io_upd_q;    // Registered update pulse.

    assign sw_update = i_req.wr && hit(i_req.addr, `ADDR_UPDATE_STROBE)
                       && i_req.wdata[`UPD_STROBE_BIT];
    assign io_update = sw_update || (pins_q[PW-1] && !upd_pin_d1_q);

    // Readback select, returned to default during soft reset.
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            // Active.
            rb_sel_q <= 1'b0;
        end else if (soft_rst) begin
            rb_sel_q <= 1'(`READBACK_RESET);
        end else if (i_req.wr && hit(i_req.addr, `ADDR_READBACK_SELECT)) begin
            rb_sel_q <= i_req.wdata[`RB_SELECT_BIT];
        end
    end

    // Update pulse to the buffered registers; the strobe itself stores nothing.
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            // No update.
            io_upd_q <= 1'b0;
        end else begin
            io_upd_q <= io_update;
        end
    end

    // ****************************************************************
    // Power-down and enable.
    // ****************************************************************

    power_ctrl_t pwr_q;   // Power-down and enable register.

    // Default comes from the straps at capture and again on soft reset.
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            // Zero first.
            pwr_q <= power_ctrl_t'(`POWER_PRE_STRAP);
        end else if (strap_load) begin
            pwr_q <= strap_to_power(pins_q[STRAP_WIDTH-1:0]);
        end else if (soft_rst) begin
            pwr_q <= strap_to_power(strap_q);
        end else if (i_req.wr && hit(i_req.addr, `ADDR_POWER_ENABLE_CONTROL)) begin
            // Host write.
            pwr_q <= power_ctrl_t'(i_req.wdata);
        end
    end

    // ****************************************************************
    // Reset registers.
    // ****************************************************************

    pulse_rst_t pulse_q;  // One-cycle reset pulses.
    held_rst_t  held_q;   // Held reset levels.

    // Write of ones gives one pulse; the register then clears and always reads zero.
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            // No pulse.
            pulse_q <= '0;
        end else if (!soft_rst && i_req.wr && hit(i_req.addr, `ADDR_PULSE_RESETS)) begin
            pulse_q <= pulse_rst_t'(i_req.wdata & `PULSE_RESETS_MASK);
        end else begin
            // Self-clear.
            pulse_q <= '0;
        end
    end

    // Held levels stay until the host writes them away or a soft reset clears them.
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            // Nothing held.
            held_q <= held_rst_t'(`HELD_RESETS_RESET);
        end else if (soft_rst) begin
            held_q <= held_rst_t'(`HELD_RESETS_RESET);
        end else if (i_req.wr && hit(i_req.addr, `ADDR_HELD_RESETS)) begin
            held_q <= held_rst_t'(i_req.wdata & `HELD_RESETS_MASK);
        end
    end

    // ****************************************************************
    // Read path.
    // ****************************************************************

    logic [7:0] rd_mux;   // Value for the addressed register.
    logic [7:0] rdata_q;  // Registered read data.
    logic       rvalid_q; // Read data valid.

    // Address decode; reserved and unmapped addresses read zero.
    always_comb begin
        if (i_req.addr == `ADDR_SERIAL_PORT_CONFIG) begin
            rd_mux = cfg_read;
        end else if (i_req.addr == `ADDR_PART_IDENTIFIER_LOW) begin
            rd_mux = PART_IDENTIFIER_HIGH_LOW;
        end else if (i_req.addr == `ADDR_PART_IDENTIFIER_HIGH) begin
            rd_mux = PART_IDENTIFIER_HIGH_HIGH;
        end else if (i_req.addr == `ADDR_READBACK_SELECT) begin
            rd_mux = {7'h00, rb_sel_q};
        end else if (i_req.addr == `ADDR_POWER_ENABLE_CONTROL) begin
            rd_mux = pwr_q;
        end else if (i_req.addr == `ADDR_HELD_RESETS) begin
            rd_mux = held_q;
        end else begin
            rd_mux = 8'h00;
        end
    end

    // Read data appears one cycle after the request.
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            // Nothing read.
            rdata_q  <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            // Valid pulse.
            rvalid_q <= i_req.rd;
            if (i_req.rd) begin
                rdata_q <= rd_mux;
            end
        end
    end

    // ****************************************************************
    // Outputs.
    // ****************************************************************

    assign o_rdata             = rdata_q;
    assign o_rd_valid          = rvalid_q;
    assign o_lsb_first         = lsb_active_q;
    assign o_serial_out_pin_en = cfg_q[`CFG_SDO_ACTIVE_BIT];
    assign o_soft_reset        = soft_rst;
    assign o_read_buffered     = rb_sel_q;
    assign o_io_update         = io_upd_q;
    assign o_strap_values      = strap_q;
    assign o_power             = pwr_q;
    assign o_full_power_down   = pwr_q.full_power_down || pins_q[PW-2];
    assign o_pulse_rst         = pulse_q;
    assign o_held_rst          = held_q;

endmodule : serial_config_power_reset_regs

`default_nettype wire

// ===== include/serial_config_power_reset_regs_defs.svh
// Offsets, field positions, reset values and timing counts of the control register bank.
`ifndef SERIAL_CONFIG_POWER_RESET_REGS_DEFS_SVH
`define SERIAL_CONFIG_POWER_RESET_REGS_DEFS_SVH

// ****************************************************************
// Register offsets (byte addresses on the serial port).
// ****************************************************************
`define ADDR_SERIAL_PORT_CONFIG   16'h0000
`define ADDR_RESERVED_A           16'h0001
`define ADDR_PART_IDENTIFIER_LOW  16'h0002
`define ADDR_PART_IDENTIFIER_HIGH 16'h0003
`define ADDR_READBACK_SELECT      16'h0004
`define ADDR_UPDATE_STROBE        16'h0005
`define ADDR_POWER_ENABLE_CONTROL 16'h0010
`define ADDR_RESERVED_B           16'h0011
`define ADDR_PULSE_RESETS         16'h0012
`define ADDR_HELD_RESETS          16'h0013

// ****************************************************************
// Field positions.
// ****************************************************************
`define CFG_SDO_ACTIVE_BIT   0
`define CFG_LSB_FIRST_BIT    1
`define CFG_SOFT_RESET_BIT   2
`define CFG_LONG_INSTR_BIT   3
`define RB_SELECT_BIT        0
`define UPD_STROBE_BIT       0
`define STRAP_CMOS_BIT       0
`define STRAP_DOUBLER_BIT    1

// ****************************************************************
// Reset values and write masks.
// ****************************************************************
`define CFG_LOW_RESET        4'h8
`define READBACK_RESET       8'h00
`define HELD_RESETS_RESET    8'h00
`define HELD_RESETS_MASK     8'h8F
`define PULSE_RESETS_MASK    8'hBF
`define POWER_PRE_STRAP      8'h00

// ****************************************************************
// Timing counts.
// ****************************************************************
`define STRAP_SETTLE_CYCLES  3'h4

`endif

// ===== include/serial_config_power_reset_regs_pkg.sv
// Types shared by the control register bank.
package serial_config_power_reset_regs_pkg;

    // Power-down and enable register, bit 7 down to bit 0.
    typedef struct packed {
        logic pd_hstl_driver;
        logic en_cmos_driver;
        logic en_output_doubler;
        logic pd_system_clock_pll;
        logic pd_reference_a;
        logic pd_reference_b;
        logic full_power_down;
        logic digital_power_down;
    } power_ctrl_t;

    // One-cycle reset pulses, bit 7 down to bit 0.
    typedef struct packed {
        logic history;
        logic unused_6;
        logic irq;
        logic fine_phase_detector;
        logic coarse_phase_detector;
        logic loop_filter;
        logic comb_integrator;
        logic synthesizer;
    } pulse_rst_t;

    // Held reset levels, bit 7 down to bit 0.
    typedef struct packed {
        logic pd_fundamental;
        logic [2:0] unused_6_4;
        logic feedback_prescaler;
        logic reference_prescaler;
        logic feedback_divider;
        logic reference_divider;
    } held_rst_t;

    // Register access request from the serial port engine.
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } reg_req_t;

endpackage : serial_config_power_reset_regs_pkg

// ===== testbench/scprr_asserts.sv
// Port checker for the control register bank.
`timescale 1ns/1ps
`default_nettype none

module scprr_asserts
    import serial_config_power_reset_regs_pkg::*;
#(
    parameter logic [7:0] PART_IDENTIFIER_HIGH_LOW  = 8'h5A,  // Arbitrary identification value.
    parameter logic [7:0] PART_IDENTIFIER_HIGH_HIGH = 8'hA5,  // Arbitrary identification value.
    parameter int         STRAP_WIDTH  = 4
) (
    input wire logic                   i_clk,
    input wire logic                   i_sys_rst,
    input wire reg_req_t               i_req,
    input wire logic                   i_power_down_pin,
    input wire logic [7:0]             o_rdata,
    input wire logic                   o_lsb_first,
    input wire logic                   o_serial_out_pin_en,
    input wire logic                   o_soft_reset,
    input wire logic                   o_read_buffered,
    input wire logic                   o_io_update,
    input wire logic [STRAP_WIDTH-1:0] o_strap_values,
    input wire power_ctrl_t            o_power,
    input wire logic                   o_full_power_down,
    input wire pulse_rst_t             o_pulse_rst,
    input wire held_rst_t              o_held_rst
);
    // All checks run on the one clock and pause during hard reset.
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    a_cfg_mirror_read: assert property (
        i_req.rd && i_req.addr == 16'h0000 |=> o_rdata[3] &&
        o_rdata[7:4] == {o_rdata[0], o_rdata[1], o_rdata[2], o_rdata[3]})
        else $error("config readback not mirrored");
    a_part_identifier_high_fixed: assert property (
        i_req.rd && i_req.addr[15:1] == 15'h0001 |=>
        o_rdata == ($past(i_req.addr[0]) ? PART_IDENTIFIER_HIGH_HIGH : PART_IDENTIFIER_HIGH_LOW))
        else $error("part identifier value wrong");
    a_reserved_zero: assert property (
        i_req.rd && (i_req.addr == 16'h0001 || i_req.addr == 16'h0011) |=> o_rdata == 8'h00)
        else $error("reserved register not zero");
    a_cfg_fields: assert property (
        i_req.wr && i_req.addr == 16'h0000 |=> o_serial_out_pin_en == $past(i_req.wdata[0])
        && o_soft_reset == $past(i_req.wdata[2]))
        else $error("config field outputs wrong");
    a_lsb_set: assert property (
        i_req.wr && i_req.addr == 16'h0000 && i_req.wdata[1] |-> ##2 o_lsb_first)
        else $error("lsb first not applied");
    a_lsb_clear_update: assert property (
        $fell(o_lsb_first) |-> o_io_update)
        else $error("msb first taken without update");
    a_strobe_update: assert property (
        i_req.wr && i_req.addr == 16'h0005 && i_req.wdata[0] |=> o_io_update)
        else $error("update strobe gave no update");
    a_pulse_map: assert property (
        i_req.wr && i_req.addr == 16'h0012 && !o_soft_reset |=>
        o_pulse_rst == ($past(i_req.wdata) & 8'hBF))
        else $error("reset pulses do not match write");
    a_held_write: assert property (
        i_req.wr && i_req.addr == 16'h0013 && !o_soft_reset |=>
        o_held_rst == ($past(i_req.wdata) & 8'h8F))
        else $error("held resets do not match write");
    a_soft_defaults: assert property (
        o_soft_reset |=> o_held_rst == 8'h00 && !o_read_buffered &&
        o_power == {1'b0, o_strap_values[0], o_strap_values[1], 5'h00})
        else $error("soft reset did not restore defaults");
    a_full_pd_join: assert property (
        (i_power_down_pin [*6] or o_power.full_power_down) |-> o_full_power_down)
        else $error("full power down missing");
endmodule : scprr_asserts

`default_nettype wire

// ===== testbench/host_model.sv
// Host controller model that issues register requests one cycle each.
`timescale 1ns/1ps
`default_nettype none

module host_model
    import serial_config_power_reset_regs_pkg::*;
(
    input  wire logic     i_clk,
    output var  reg_req_t o_req
);
    // Idle request until the first transfer.
    initial o_req = '0;

    // host request pacing
    // A write is held one cycle; released lines show the inverse value.
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge i_clk);
        o_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask : wr

    // A read is held one cycle; the bench collects the answer.
    task automatic rd(input logic [15:0] a);
        @(posedge i_clk);
        o_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge i_clk);
        o_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
    endtask : rd
endmodule : host_model

`default_nettype wire

// ===== testbench/tb.sv
// Self-checking bench for the control register bank.
`timescale 1ns/1ps
`default_nettype none

module tb;
    import serial_config_power_reset_regs_pkg::*;
    logic        i_clk, i_sys_rst, upd_pin, pd_pin;
    logic [3:0]  straps, st, o_strap_values;
    reg_req_t    req;
    logic [7:0]  o_rdata, pexp, expq[$];
    logic        o_rd_valid, o_lsb_first, o_serial_out_pin_en, o_soft_reset;
    logic        o_read_buffered, o_io_update, o_full_power_down;
    power_ctrl_t o_power;
    pulse_rst_t  o_pulse_rst;
    held_rst_t   o_held_rst;
    logic [15:0] lf;
    int          n_fail, n_compared, i;
    logic [15:0] za [7] = '{16'h0001, 16'h0002, 16'h0003, 16'h0005, 16'h0011, 16'h0012, 16'h007F};
    logic [7:0]  ze [7] = '{8'h00, 8'h5A, 8'hA5, 8'h00, 8'h00, 8'h00, 8'h00};

    serial_config_power_reset_regs serial_config_power_reset_regs_inst (
        .i_clk, .i_sys_rst, .i_req(req), .i_io_update_pin(upd_pin),
        .i_power_down_pin(pd_pin), .i_startup_strap_pins(straps), .o_rdata, .o_rd_valid,
        .o_lsb_first, .o_serial_out_pin_en, .o_soft_reset, .o_read_buffered, .o_io_update,
        .o_strap_values, .o_power, .o_full_power_down, .o_pulse_rst, .o_held_rst);
    host_model host_model_inst (.i_clk, .o_req(req));

    // Free-running 100 MHz clock.
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    // Pseudo-random sequence for data and strap values.
    function automatic logic [15:0] nxt(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : nxt

    // Compares one value and counts the outcome.
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Notes the expected data, then has the host read.
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        expq.push_back(e);
        host_model_inst.rd(a);
    endtask : rd

    // Moves to just after the next rising edge.
    task automatic step();
        @(posedge i_clk);
        #1;
    endtask : step

    task automatic tally_and_finish();
        n_fail += expq.size();
        $display("Compared %0d values, %0d mismatches", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : tally_and_finish

    // Each read answer is matched with the oldest note.
    always @(posedge i_clk) begin
        if (o_rd_valid === 1'b1) begin
            chk("read data", (expq.size() > 0) ? expq.pop_front() : 8'hXX, o_rdata);
        end
    end

    // Cuts a hang short.
    initial begin
        repeat (20000) @(posedge i_clk);
        n_fail++;
        tally_and_finish();
    end

    initial begin
        n_fail = 0;
        n_compared = 0;
        lf = 16'hC51F;
        i_sys_rst = 1'b1;
        upd_pin = 1'b0;
        pd_pin = 1'b0;
        st = lf[3:0];
        straps = st;
        pexp = {1'b0, st[0], st[1], 5'h00};
        repeat (16) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        repeat (8) @(posedge i_clk);
        rd(16'h0000, 8'h18);
        rd(16'h0010, pexp);
        for (i = 0; i < 7; i++) begin
            host_model_inst.wr(za[i], 8'hFF);
            rd(za[i], ze[i]);
        end
        $display("test reset values done");
        host_model_inst.wr(16'h0000, 8'h03);
        step();
        chk("sdo enable", 8'h01, o_serial_out_pin_en);
        chk("lsb first", 8'h01, o_lsb_first);
        rd(16'h0000, 8'hDB);
        host_model_inst.wr(16'h0000, 8'h01);
        step();
        step();
        chk("lsb held", 8'h01, o_lsb_first);
        host_model_inst.wr(16'h0005, 8'h01);
        #1 chk("update strobe", 8'h01, o_io_update);
        step();
        chk("msb after strobe", 8'h00, o_lsb_first);
        host_model_inst.wr(16'h0000, 8'h03);
        host_model_inst.wr(16'h0000, 8'h01);
        @(posedge i_clk) upd_pin <= 1'b1;
        for (i = 0; i < 12 && o_io_update !== 1'b1; i++) step();
        chk("update pin", 8'h01, o_io_update);
        if (i == 12) tally_and_finish();
        step();
        chk("msb after pin", 8'h00, o_lsb_first);
        @(posedge i_clk) upd_pin <= 1'b0;
        $display("test bit order done");
        for (i = 0; i < 4; i++) begin
            lf = nxt(lf);
            host_model_inst.wr(16'h0010, lf[7:0]);
            #1 chk("power", lf[7:0], o_power);
            chk("full pd bit", {7'h00, lf[1]}, o_full_power_down);
            rd(16'h0010, lf[7:0]);
        end
        host_model_inst.wr(16'h0010, 8'h00);
        @(posedge i_clk) pd_pin <= 1'b1;
        for (i = 0; i < 12 && o_full_power_down !== 1'b1; i++) step();
        chk("pd pin", 8'h01, o_full_power_down);
        if (i == 12) tally_and_finish();
        @(posedge i_clk) pd_pin <= 1'b0;
        $display("test power done");
        for (i = 0; i < 8; i++) begin
            host_model_inst.wr(16'h0012, 8'h01 << i);
            #1 chk("pulse", (8'h01 << i) & 8'hBF, o_pulse_rst);
            step();
            chk("pulse end", 8'h00, o_pulse_rst);
        end
        host_model_inst.wr(16'h0012, 8'h1F);
        for (i = 0; i < 3; i++) begin
            lf = nxt(lf);
            host_model_inst.wr(16'h0013, lf[7:0]);
            #1 chk("held", lf[7:0] & 8'h8F, o_held_rst);
            rd(16'h0013, lf[7:0] & 8'h8F);
        end
        host_model_inst.wr(16'h0004, 8'hFF);
        #1 chk("readback select", 8'h01, o_read_buffered);
        rd(16'h0004, 8'h01);
        $display("test resets done");
        host_model_inst.wr(16'h0000, 8'h05);
        @(posedge i_clk) straps <= ~st;
        step();
        step();
        chk("soft held", 8'h00, o_held_rst);
        chk("soft readback", 8'h00, o_read_buffered);
        chk("straps kept", {4'h0, st}, o_strap_values);
        rd(16'h0010, pexp);
        host_model_inst.wr(16'h0013, 8'h01);
        rd(16'h0013, 8'h00);
        rd(16'h0000, 8'hBD);
        host_model_inst.wr(16'h0000, 8'h01);
        host_model_inst.wr(16'h0013, 8'h01);
        rd(16'h0013, 8'h01);
        repeat (4) step();
        $display("test soft reset done");
        tally_and_finish();
    end
endmodule : tb

bind serial_config_power_reset_regs scprr_asserts #(
    .PART_IDENTIFIER_HIGH_LOW(PART_IDENTIFIER_HIGH_LOW), .PART_IDENTIFIER_HIGH_HIGH(PART_IDENTIFIER_HIGH_HIGH), .STRAP_WIDTH(STRAP_WIDTH)
) scprr_asserts_inst (
    .i_clk, .i_sys_rst, .i_req, .i_power_down_pin, .o_rdata, .o_lsb_first,
    .o_serial_out_pin_en, .o_soft_reset, .o_read_buffered, .o_io_update,
    .o_strap_values, .o_power, .o_full_power_down, .o_pulse_rst, .o_held_rst);

`default_nettype wire
